// [bench/ptei_top_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module ptei_chk
    import ptei_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [ADDR_W-1:0] bus_addr_in,
    input wire logic [DATA_W-1:0] bus_wdata_in,
    input wire logic bus_write_in,
    input wire logic bus_read_in,
    input wire logic [DATA_W-1:0] bus_rdata_out,
    input wire logic cpu_sleep_state_in,
    input wire logic latency_fixed_out,
    input wire logic fixed_latency_trigger_out,
    input wire logic variable_latency_trigger_out,
    input wire logic cpu_sleep_entry_event_out,
    input wire logic cpu_sleep_exit_event_out,
    input wire logic irq_out
);
    logic wr_fix;
    logic wr_var;
    assign wr_fix = bus_write_in && bus_addr_in == OFF_FIXED_LAT_TASK && bus_wdata_in[0];
    assign wr_var = bus_write_in && bus_addr_in == OFF_VAR_LAT_TASK && bus_wdata_in[0];
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    fixed_trig_a: assert property (
        wr_fix |=> fixed_latency_trigger_out && latency_fixed_out)
        else $error("fixed trigger missing");
    trig_quiet_a: assert property (!wr_fix |=> !fixed_latency_trigger_out)
        else $error("spurious fixed trigger");
    var_trig_a: assert property (
        wr_var |=> variable_latency_trigger_out && !latency_fixed_out)
        else $error("variable trigger missing");
    sleep_entry_a: assert property (
        $rose(cpu_sleep_state_in) |-> ##[2:4] cpu_sleep_entry_event_out)
        else $error("entry event missing");
    sleep_exit_a: assert property (
        $fell(cpu_sleep_state_in) |-> ##[2:4] cpu_sleep_exit_event_out)
        else $error("exit event missing");
    set_read_a: assert property ((bus_write_in && bus_addr_in == OFF_IRQ_ENABLE_SET) ##1
        (bus_read_in && bus_addr_in == OFF_IRQ_ENABLE_SET) |=>
        (bus_rdata_out[2:0] & $past(bus_wdata_in[2:0], 2)) == $past(bus_wdata_in[2:0], 2))
        else $error("enable set lost");
    clr_read_a: assert property ((bus_write_in && bus_addr_in == OFF_IRQ_ENABLE_CLR) ##1
        (bus_read_in && bus_addr_in == OFF_IRQ_ENABLE_CLR) |=>
        (bus_rdata_out[2:0] & $past(bus_wdata_in[2:0], 2)) == 3'h0)
        else $error("enable clear lost");
    shared_read_a: assert property ((bus_read_in && bus_addr_in == OFF_IRQ_ENABLE_SET) ##1
        (bus_read_in && bus_addr_in == OFF_IRQ_ENABLE_CLR) |=>
        bus_rdata_out == $past(bus_rdata_out))
        else $error("enable views differ");
    irq_mask_a: assert property ((bus_write_in && bus_addr_in == OFF_IRQ_ENABLE_CLR &&
        bus_wdata_in[2:0] == 3'h7) |-> ##2 !irq_out)
        else $error("irq not masked");
endmodule
bind ptei_top ptei_chk i_ptei_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_write_in(bus_write_in),
    .bus_read_in(bus_read_in), .bus_rdata_out(bus_rdata_out),
    .cpu_sleep_state_in(cpu_sleep_state_in), .latency_fixed_out(latency_fixed_out),
    .fixed_latency_trigger_out(fixed_latency_trigger_out),
    .variable_latency_trigger_out(variable_latency_trigger_out),
    .cpu_sleep_entry_event_out(cpu_sleep_entry_event_out),
    .cpu_sleep_exit_event_out(cpu_sleep_exit_event_out), .irq_out(irq_out));
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import ptei_pkg::*;
;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [ADDR_W-1:0] bus_addr_in = '0;
    logic [DATA_W-1:0] bus_wdata_in = '0;
    logic bus_write_in = 1'b0;
    logic bus_read_in = 1'b0;
    logic supply_drop_warning_in = 1'b0;
    logic cpu_sleep_state_in = 1'b0;
    logic [DATA_W-1:0] bus_rdata_out;
    wire latency_fixed_out;
    wire [5:0] outs;
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 83;
    logic [DATA_W-1:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [2:0] en_m = 3'h0;
    logic [2:0] v;

    always #5 clock_in = ~clock_in;

    ptei_top i_ptei_top (.clock_in(clock_in), .rst_n_in(rst_n_in), .bus_addr_in(bus_addr_in),
        .bus_wdata_in(bus_wdata_in), .bus_write_in(bus_write_in), .bus_read_in(bus_read_in),
        .bus_rdata_out(bus_rdata_out), .supply_drop_warning_in(supply_drop_warning_in),
        .cpu_sleep_state_in(cpu_sleep_state_in), .latency_fixed_out(latency_fixed_out),
        .fixed_latency_trigger_out(outs[1]), .variable_latency_trigger_out(outs[2]),
        .supply_drop_warning_event_out(outs[3]), .cpu_sleep_entry_event_out(outs[4]),
        .cpu_sleep_exit_event_out(outs[5]), .irq_out(outs[0]));

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One bus cycle; for a read, d is the expected read data.
    task automatic acc(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        bus_write_in <= w;
        bus_read_in <= r;
        bus_addr_in <= a;
        bus_wdata_in <= d;
        if (r) begin
            exp_q.push_back(d);
        end
        @(posedge clock_in);
    endtask

    // Drops the strobes and waits, bounded, for one output bit to go high.
    task automatic wait_out(input int i);
        int k;
        bus_write_in <= 1'b0;
        bus_read_in <= 1'b0;
        for (k = 0; k < 8 && outs[i] !== 1'b1; k++) begin
            @(negedge clock_in);
        end
        check({31'h0, outs[i]}, 32'h1);
        if (outs[i] !== 1'b1) begin
            conclude();
        end
        @(posedge clock_in);
    endtask

    always @(posedge clock_in) begin
        if (rd_seen) begin
            check(bus_rdata_out, exp_q.pop_front());
        end
        rd_seen <= bus_read_in;
    end

    initial begin
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        acc(0, 1, OFF_IRQ_ENABLE_SET, 32'h0);
        acc(0, 1, OFF_IRQ_ENABLE_CLR, 32'h0);
        acc(0, 1, OFF_FIXED_LAT_TASK, 32'h0);
        acc(0, 1, OFF_VAR_LAT_TASK, 32'h0);
        acc(0, 1, 12'habc, 32'h0);
        acc(0, 1, OFF_LATENCY_STATUS, 32'h0);
        $display("reset values done");
        for (int n = 0; n < 12; n++) begin
            v = 3'($random(seed));
            en_m = n[0] ? (en_m & ~v) : (en_m | v);
            acc(1, 0, n[0] ? OFF_IRQ_ENABLE_CLR : OFF_IRQ_ENABLE_SET, {29'h0, v});
            acc(0, 1, n[1] ? OFF_IRQ_ENABLE_CLR : OFF_IRQ_ENABLE_SET, {29'h0, en_m});
        end
        $display("enable test done");
        acc(1, 0, OFF_FIXED_LAT_TASK, 32'h1);
        wait_out(1);
        check({31'h0, latency_fixed_out}, 32'h1);
        acc(0, 1, OFF_LATENCY_STATUS, 32'h1);
        acc(1, 0, OFF_VAR_LAT_TASK, 32'h1);
        wait_out(2);
        check({31'h0, latency_fixed_out}, 32'h0);
        acc(0, 1, OFF_LATENCY_STATUS, 32'h0);
        $display("latency test done");
        acc(1, 0, OFF_IRQ_ENABLE_SET, 32'h7);
        cpu_sleep_state_in <= 1'b1;
        wait_out(4);
        wait_out(0);
        acc(0, 1, OFF_SLEEP_ENTRY_EVT, 32'h1);
        acc(1, 0, OFF_SLEEP_ENTRY_EVT, 32'h0);
        repeat (3) acc(0, 0, 12'h0, 32'h0);
        check({31'h0, outs[0]}, 32'h0);
        cpu_sleep_state_in <= 1'b0;
        wait_out(5);
        acc(0, 1, OFF_SLEEP_EXIT_EVT, 32'h1);
        acc(1, 0, OFF_SLEEP_EXIT_EVT, 32'h0);
        supply_drop_warning_in <= 1'b1;
        wait_out(3);
        wait_out(0);
        acc(1, 0, OFF_IRQ_ENABLE_CLR, 32'h7);
        repeat (3) acc(0, 0, 12'h0, 32'h0);
        check({31'h0, outs[0]}, 32'h0);
        acc(0, 1, OFF_SUPPLY_WARN_EVT, 32'h1);
        acc(1, 0, OFF_SUPPLY_WARN_EVT, 32'h0);
        acc(0, 1, OFF_SUPPLY_WARN_EVT, 32'h0);
        // A software-set flag must raise the request and clear through the status word.
        acc(1, 0, OFF_IRQ_ENABLE_SET, 32'h4);
        acc(1, 0, OFF_SLEEP_EXIT_EVT, 32'h1);
        wait_out(0);
        acc(0, 1, OFF_IRQ_STATUS, 32'h4);
        acc(1, 0, OFF_IRQ_STATUS, 32'h4);
        repeat (3) acc(0, 0, 12'h0, 32'h0);
        check({31'h0, outs[0]}, 32'h0);
        acc(0, 1, OFF_SLEEP_EXIT_EVT, 32'h0);
        acc(0, 0, 12'h0, 32'h0);
        supply_drop_warning_in <= 1'b0;
        @(posedge clock_in);
        $display("event test done");
        conclude();
    end
endmodule
`default_nettype wire

// [include/ptei_pkg.sv]
package ptei_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_FIXED_LAT_TASK = 12'h078;
    localparam logic [ADDR_W-1:0] OFF_VAR_LAT_TASK = 12'h07c;
    localparam logic [ADDR_W-1:0] OFF_SUPPLY_WARN_EVT = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_SLEEP_ENTRY_EVT = 12'h114;
    localparam logic [ADDR_W-1:0] OFF_SLEEP_EXIT_EVT = 12'h118;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_SET = 12'h304;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_CLR = 12'h308;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 12'h600;
    localparam logic [ADDR_W-1:0] OFF_LATENCY_STATUS = 12'h604;

    // Field positions.
    localparam int TASK_BIT = 0;
    localparam int EVT_FLAG_BIT = 0;
    localparam int NUM_EVT = 3;
    localparam int IRQ_SUPPLY_WARN_BIT = 0;
    localparam int IRQ_SLEEP_ENTRY_BIT = 1;
    localparam int IRQ_SLEEP_EXIT_BIT = 2;
    localparam int LAT_FIXED_BIT = 0;

    // Reset values.
    localparam logic [NUM_EVT-1:0] IRQ_ENABLE_RST = 3'h0;
    localparam logic [NUM_EVT-1:0] EVT_FLAG_RST = 3'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // Latency operating mode, one-hot.
    typedef enum logic [1:0] {
        PTEI_LAT_VARIABLE = 2'b01,
        PTEI_LAT_FIXED = 2'b10
    } ptei_lat_mode_t;

    localparam ptei_lat_mode_t LAT_MODE_RST = PTEI_LAT_VARIABLE;

endpackage

// [rtl/ptei_sync.sv]
`timescale 1ns/10ps
`default_nettype none

// Two flip-flop synchroniser; the first stage feeds only the second.
module ptei_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;

endmodule

`default_nettype wire

// [rtl/ptei_top.sv]
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Writing one at 0x078 selects fixed latency.
// - Writing one at 0x07c selects variable latency.
// - Sleep entry sets the entry event flag.
// - Sleep exit sets the exit event flag.
// - Enable-set write ones enable those interrupts.
// - Enable-clear write ones disable those interrupts.
// - Both enable registers read shared state, reset zero.
module ptei_top
    import ptei_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [ADDR_W-1:0] bus_addr_in,
    input wire logic [DATA_W-1:0] bus_wdata_in,
    input wire logic bus_write_in,
    input wire logic bus_read_in,
    output logic [DATA_W-1:0] bus_rdata_out,
    input wire logic supply_drop_warning_in,
    input wire logic cpu_sleep_state_in,
    output logic latency_fixed_out,
    output logic fixed_latency_trigger_out,
    output logic variable_latency_trigger_out,
    output logic supply_drop_warning_event_out,
    output logic cpu_sleep_entry_event_out,
    output logic cpu_sleep_exit_event_out,
    output logic irq_out
);

    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] offset);
        hit = (addr == offset);
    endfunction

    // Reset release path: asserted at once, released after two edges.
    logic rst_sync_n;

    ptei_sync #(
        .WIDTH(1)
    ) u_rst_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .async_in(1'b1),
        .sync_out(rst_sync_n)
    );

    // Both status inputs come from outside the clock domain.
    logic [1:0] pin_sync;
    logic warn_level;
    logic sleep_level;

    ptei_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_sync_n),
        .async_in({cpu_sleep_state_in, supply_drop_warning_in}),
        .sync_out(pin_sync)
    );

    assign warn_level = pin_sync[0];
    assign sleep_level = pin_sync[1];

    // Register decode.
    logic wr_fixed_task;
    logic wr_var_task;
    logic wr_warn_evt;
    logic wr_entry_evt;
    logic wr_exit_evt;
    logic wr_en_set;
    logic wr_en_clr;
    logic wr_status;

    assign wr_fixed_task = bus_write_in && hit(bus_addr_in, OFF_FIXED_LAT_TASK);
    assign wr_var_task = bus_write_in && hit(bus_addr_in, OFF_VAR_LAT_TASK);
    assign wr_warn_evt = bus_write_in && hit(bus_addr_in, OFF_SUPPLY_WARN_EVT);
    assign wr_entry_evt = bus_write_in && hit(bus_addr_in, OFF_SLEEP_ENTRY_EVT);
    assign wr_exit_evt = bus_write_in && hit(bus_addr_in, OFF_SLEEP_EXIT_EVT);
    assign wr_en_set = bus_write_in && hit(bus_addr_in, OFF_IRQ_ENABLE_SET);
    assign wr_en_clr = bus_write_in && hit(bus_addr_in, OFF_IRQ_ENABLE_CLR);
    assign wr_status = bus_write_in && hit(bus_addr_in, OFF_IRQ_STATUS);

    // Task triggers and latency mode.
    logic fixed_trig;
    logic var_trig;
    ptei_lat_mode_t lat_mode_q;
    ptei_lat_mode_t lat_mode_d;
    logic fixed_trig_q;
    logic var_trig_q;

    assign fixed_trig = wr_fixed_task && bus_wdata_in[TASK_BIT];
    assign var_trig = wr_var_task && bus_wdata_in[TASK_BIT];

    always_comb begin
        case (lat_mode_q)
            PTEI_LAT_VARIABLE: begin
                if (fixed_trig) begin
                    lat_mode_d = PTEI_LAT_FIXED;
                end else begin
                    lat_mode_d = PTEI_LAT_VARIABLE;
                end
            end
            PTEI_LAT_FIXED: begin
                if (var_trig) begin
                    lat_mode_d = PTEI_LAT_VARIABLE;
                end else begin
                    lat_mode_d = PTEI_LAT_FIXED;
                end
            end
            default: begin
                lat_mode_d = LAT_MODE_RST;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lat_mode_q <= LAT_MODE_RST;
        end else begin
            lat_mode_q <= lat_mode_d;
        end
    end

    // Each accepted trigger is also passed on as a one-cycle pulse.
    always_ff @(posedge clock_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fixed_trig_q <= 1'b0;
            var_trig_q <= 1'b0;
        end else begin
            fixed_trig_q <= fixed_trig;
            var_trig_q <= var_trig;
        end
    end

    // Event detection on the synchronised levels.
    logic warn_prev_q;
    logic sleep_prev_q;
    logic [NUM_EVT-1:0] evt_hit;

    always_ff @(posedge clock_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            warn_prev_q <= 1'b0;
            sleep_prev_q <= 1'b0;
        end else begin
            warn_prev_q <= warn_level;
            sleep_prev_q <= sleep_level;
        end
    end

    always_comb begin
        evt_hit = EVT_FLAG_RST;
        evt_hit[IRQ_SUPPLY_WARN_BIT] = warn_level && !warn_prev_q;
        evt_hit[IRQ_SLEEP_ENTRY_BIT] = sleep_level && !sleep_prev_q;
        evt_hit[IRQ_SLEEP_EXIT_BIT] = !sleep_level && sleep_prev_q;
    end

    // Event flags. A hardware event in the same cycle as a software
    // clear wins, so no event is lost.
    logic [NUM_EVT-1:0] evt_q;
    logic [NUM_EVT-1:0] evt_d;
    logic [NUM_EVT-1:0] evt_wr;
    logic [NUM_EVT-1:0] status_clr;

    assign evt_wr[IRQ_SUPPLY_WARN_BIT] = wr_warn_evt;
    assign evt_wr[IRQ_SLEEP_ENTRY_BIT] = wr_entry_evt;
    assign evt_wr[IRQ_SLEEP_EXIT_BIT] = wr_exit_evt;
    assign status_clr = wr_status ? bus_wdata_in[NUM_EVT-1:0] : EVT_FLAG_RST;

    always_comb begin
        evt_d = evt_q;
        for (int i = 0; i < NUM_EVT; i++) begin
            if (evt_wr[i]) begin
                evt_d[i] = bus_wdata_in[EVT_FLAG_BIT];
            end
            if (status_clr[i]) begin
                evt_d[i] = 1'b0;
            end
            if (evt_hit[i]) begin
                evt_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            evt_q <= EVT_FLAG_RST;
        end else begin
            evt_q <= evt_d;
        end
    end

    // Event pulses for other blocks, one cycle per detected event.
    logic [NUM_EVT-1:0] evt_pulse_q;

    always_ff @(posedge clock_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            evt_pulse_q <= EVT_FLAG_RST;
        end else begin
            evt_pulse_q <= evt_hit;
        end
    end

    // Shared interrupt enable state; set and clear in one cycle cannot
    // happen because only one strobe is live at a time.
    logic [NUM_EVT-1:0] irq_en_q;

    always_ff @(posedge clock_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_en_q <= IRQ_ENABLE_RST;
        end else if (wr_en_set) begin
            irq_en_q <= irq_en_q | bus_wdata_in[NUM_EVT-1:0];
        end else if (wr_en_clr) begin
            irq_en_q <= irq_en_q & ~bus_wdata_in[NUM_EVT-1:0];
        end
    end

    // Interrupt level.
    logic irq_q;

    always_ff @(posedge clock_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_q & irq_en_q);
        end
    end

    // Read path: data stands only in the cycle after the strobe.
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;

    always_comb begin
        rdata_d = RDATA_RST;
        if (bus_read_in) begin
            case (bus_addr_in)
                OFF_SUPPLY_WARN_EVT: begin
                    rdata_d[EVT_FLAG_BIT] = evt_q[IRQ_SUPPLY_WARN_BIT];
                end
                OFF_SLEEP_ENTRY_EVT: begin
                    rdata_d[EVT_FLAG_BIT] = evt_q[IRQ_SLEEP_ENTRY_BIT];
                end
                OFF_SLEEP_EXIT_EVT: begin
                    rdata_d[EVT_FLAG_BIT] = evt_q[IRQ_SLEEP_EXIT_BIT];
                end
                OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLR: begin
                    rdata_d[NUM_EVT-1:0] = irq_en_q;
                end
                OFF_IRQ_STATUS: begin
                    rdata_d[NUM_EVT-1:0] = evt_q;
                end
                OFF_LATENCY_STATUS: begin
                    rdata_d[LAT_FIXED_BIT] = (lat_mode_q == PTEI_LAT_FIXED);
                end
                default: begin
                    // Task registers are write-only and unmapped
                    // addresses read zero.
                    rdata_d = RDATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_q <= RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata_out = rdata_q;
    assign latency_fixed_out = (lat_mode_q == PTEI_LAT_FIXED);
    assign fixed_latency_trigger_out = fixed_trig_q;
    assign variable_latency_trigger_out = var_trig_q;
    assign supply_drop_warning_event_out = evt_pulse_q[IRQ_SUPPLY_WARN_BIT];
    assign cpu_sleep_entry_event_out = evt_pulse_q[IRQ_SLEEP_ENTRY_BIT];
    assign cpu_sleep_exit_event_out = evt_pulse_q[IRQ_SLEEP_EXIT_BIT];
    assign irq_out = irq_q;

endmodule

`default_nettype wire
